// >>> common/radio_mode_regs.svh
// Notes on behaviour
// - ramp select 0 standard, 1 fast
// - fast ramp drops hardware interframe spacing
// - idle pattern sent between ready/end and start/disabled
// - pattern 0 one, 1 zero, 2 carrier
// - writable delimiter register, resets to a7
// - repeat count zero gives one scan
// - count N gives N+1 scans, keep maximum
// - energy level reported in 0..127
`ifndef RADIO_MODE_REGS_SVH
`define RADIO_MODE_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFS_MODE_CONFIG0    12'h650
`define OFS_FRAME_DELIM     12'h660
`define OFS_SCAN_REPEAT     12'h664
`define OFS_ENERGY_LEVEL    12'h668
`define OFS_SCAN_STATUS     12'h670

// ****************************************************************
// field positions and widths
// ****************************************************************
`define MODE_RAMP_BIT       0
`define MODE_PATTERN_LSB    8
`define MODE_PATTERN_MSB    9
`define DELIM_WIDTH         8
`define REPEAT_WIDTH        24
`define LEVEL_WIDTH         7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_MODE_CONFIG0    32'h00000200
`define RST_FRAME_DELIM     8'ha7
`define RST_SCAN_REPEAT     24'h000000
`define RST_ENERGY_LEVEL    7'h00

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS       10
`define RAMP_STD_TIME_NS    40000
`define RAMP_FAST_TIME_NS   4000
`define RAMP_STD_CYCLES     ((`RAMP_STD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_FAST_CYCLES    ((`RAMP_FAST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_CNT_WIDTH      12

`endif

// >>> common/radio_mode_pkg.sv
`include "radio_mode_regs.svh"

package radio_mode_pkg;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN  = 2'b10
  } scan_state_e;

  typedef enum logic [1:0] {
    PATTERN_ONE     = 2'h0,
    PATTERN_ZERO    = 2'h1,
    PATTERN_CARRIER = 2'h2
  } idle_pattern_e;

  typedef logic [`REPEAT_WIDTH-1:0] repeat_t;
  typedef logic [`LEVEL_WIDTH-1:0]  level_t;

endpackage

// >>> common/energy_scan_if.sv
`timescale 1ns/1ps
`include "radio_mode_regs.svh"

interface energy_scan_if;
  import radio_mode_pkg::*;
  logic    start;        // one-cycle request for an operation
  repeat_t repeatCount;  // extra scans beyond the first
  logic    sampleValid;  // one scan finished
  level_t  sampleValue;  // that scan's level
  logic    busy;         // operation running
  logic    done;         // one-cycle end of operation
  level_t  level;        // maximum of the operation

  modport engine (input start, repeatCount, sampleValid, sampleValue,
                  output busy, done, level);
  modport regs   (output start, repeatCount, sampleValid, sampleValue,
                  input busy, done, level);
endinterface

// >>> hdl/energy_scan_engine.sv
`timescale 1ns/1ps
`include "radio_mode_regs.svh"

module energy_scan_engine (
  input wire logic      mclk,    // system clock
  input wire logic      sys_rst, // synchronous reset, active high
  energy_scan_if.engine scan     // link to register bank
);
  import radio_mode_pkg::*;

  scan_state_e state;
  scan_state_e next_state;
  repeat_t     remaining;
  repeat_t     next_remaining;
  level_t      maxLevel;
  level_t      next_maxLevel;
  level_t      peak;
  logic        done;
  logic        next_done;

  // ****************************************************************
  // scan sequencing
  // ****************************************************************
  always_comb begin
    next_state     = state;
    next_remaining = remaining;
    next_maxLevel  = maxLevel;
    next_done      = 1'b0;
    peak = (scan.sampleValue > maxLevel) ? scan.sampleValue : maxLevel;
    unique case (state)
      SCAN_IDLE: begin
        if (scan.start) begin
          next_state     = SCAN_RUN;
          next_remaining = scan.repeatCount;
          next_maxLevel  = '0;
        end
      end
      SCAN_RUN: begin
        if (scan.sampleValid) begin
          next_maxLevel = peak;
          if (remaining == '0) begin
            next_state = SCAN_IDLE;
            next_done  = 1'b1;
          end else begin
            next_remaining = remaining - 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state     <= SCAN_IDLE;
      remaining <= '0;
      maxLevel  <= '0;
      done      <= 1'b0;
    end else begin
      state     <= next_state;
      remaining <= next_remaining;
      maxLevel  <= next_maxLevel;
      done      <= next_done;
    end
  end

  assign scan.busy  = (state == SCAN_RUN);
  assign scan.done  = done;
  assign scan.level = maxLevel;

endmodule // energy_scan_engine

// >>> hdl/radio_mode_energy_detect_regs.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "radio_mode_regs.svh"

module radio_mode_energy_detect_regs (
  input  wire logic                          mclk,            // system clock
  input  wire logic                          sys_rst,         // sync reset, high
  // ahb-lite slave
  input  wire logic                          hsel,            // slave select
  input  wire logic [31:0]                   haddr,           // byte address
  input  wire logic [1:0]                    htrans,          // transfer type
  input  wire logic                          hwrite,          // write when high
  input  wire logic [2:0]                    hsize,           // transfer size
  input  wire logic [31:0]                   hwdata,          // write data
  input  wire logic                          hready,          // bus ready
  output      logic                          hreadyout,       // slave ready
  output      logic                          hresp,           // always okay
  output      logic [31:0]                   hrdata,          // read data
  // radio sequencing events
  input  wire logic                          readyEvent,      // ramp-up finished
  input  wire logic                          startTask,       // packet start
  input  wire logic                          endEvent,        // packet end
  input  wire logic                          disabledEvent,   // radio disabled
  // energy detect measurement
  input  wire logic                          energyScanStart, // start operation
  input  wire logic                          energySampleValid, // scan result
  input  wire radio_mode_pkg::level_t        energySample,    // scan level
  output      logic                          energyScanDone,  // operation ended
  // radio control outputs
  output      logic                          rampSpeedSelect, // 1 = fast ramp
  output      logic [`RAMP_CNT_WIDTH-1:0]    rampupCycles,    // enable ramp length
  output      logic                          interframeSpacingEnforce, // hw spacing
  output      logic                          idleTxActive,    // idle window open
  output      logic                          idleTxOne,       // emit one symbol
  output      logic                          idleTxZero,      // emit zero symbol
  output      logic                          idleTxCarrier,   // emit carrier
  output      logic [`DELIM_WIDTH-1:0]       frameDelimiter   // start delimiter
);
  import radio_mode_pkg::*;

  localparam logic [`RAMP_CNT_WIDTH-1:0] RampStd  = `RAMP_CNT_WIDTH'(`RAMP_STD_CYCLES);
  localparam logic [`RAMP_CNT_WIDTH-1:0] RampFast = `RAMP_CNT_WIDTH'(`RAMP_FAST_CYCLES);
  localparam logic [31:0]                RstMode  = `RST_MODE_CONFIG0;

  // ****************************************************************
  // registers and next values
  // ****************************************************************
  logic                      rampSel;
  logic                      next_rampSel;
  logic [1:0]                pattern;
  logic [1:0]                next_pattern;
  logic [`DELIM_WIDTH-1:0]   delim;
  logic [`DELIM_WIDTH-1:0]   next_delim;
  repeat_t                   repeatCnt;
  repeat_t                   next_repeatCnt;
  level_t                    energyLevel;
  level_t                    next_energyLevel;

  logic                      wrPending;
  logic                      next_wrPending;
  logic [11:0]               wrAddr;
  logic [11:0]               next_wrAddr;
  logic [31:0]               next_hrdata;

  logic                      idleWindow;
  logic                      next_idleWindow;
  logic                      next_idleTxOne;
  logic                      next_idleTxZero;
  logic                      next_idleTxCarrier;
  logic [`RAMP_CNT_WIDTH-1:0] next_rampupCycles;
  logic                      next_scanDone;

  logic                      addrPhase;
  logic                      writeData;

  energy_scan_if scanLink ();

  // ****************************************************************
  // energy scan engine
  // ****************************************************************
  assign scanLink.start       = energyScanStart;
  assign scanLink.repeatCount = repeatCnt;
  assign scanLink.sampleValid = energySampleValid;
  assign scanLink.sampleValue = energySample;

  energy_scan_engine u_scan (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .scan    (scanLink.engine)
  );

  // ****************************************************************
  // ahb-lite address and data phase
  // ****************************************************************
  assign addrPhase = hsel & htrans[1] & hready;
  assign writeData = wrPending;

  always_comb begin
    next_wrPending = addrPhase & hwrite;
    next_wrAddr    = addrPhase ? haddr[11:0] : wrAddr;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPending <= 1'b0;
      wrAddr    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPending <= next_wrPending;
      wrAddr    <= next_wrAddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes and hardware updates
  // ****************************************************************
  always_comb begin
    next_rampSel     = rampSel;
    next_pattern     = pattern;
    next_delim       = delim;
    next_repeatCnt   = repeatCnt;
    next_energyLevel = energyLevel;
    if (writeData) begin
      unique case (wrAddr)
        `OFS_MODE_CONFIG0: begin
          next_rampSel = hwdata[`MODE_RAMP_BIT];
          next_pattern = hwdata[`MODE_PATTERN_MSB:`MODE_PATTERN_LSB];
        end
        `OFS_FRAME_DELIM: begin
          next_delim = hwdata[`DELIM_WIDTH-1:0];
        end
        `OFS_SCAN_REPEAT: begin
          next_repeatCnt = hwdata[`REPEAT_WIDTH-1:0];
        end
        `OFS_ENERGY_LEVEL: begin
          next_energyLevel = hwdata[`LEVEL_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    // a finishing scan beats a software write in the same cycle
    if (scanLink.done) begin
      next_energyLevel = scanLink.level;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rampSel     <= RstMode[`MODE_RAMP_BIT];
      pattern     <= RstMode[`MODE_PATTERN_MSB:`MODE_PATTERN_LSB];
      delim       <= `RST_FRAME_DELIM;
      repeatCnt   <= `RST_SCAN_REPEAT;
      energyLevel <= `RST_ENERGY_LEVEL;
    end else begin
      rampSel     <= next_rampSel;
      pattern     <= next_pattern;
      delim       <= next_delim;
      repeatCnt   <= next_repeatCnt;
      energyLevel <= next_energyLevel;
    end
  end

  // ****************************************************************
  // read data, taken from next values so a read right after a write
  // sees the new contents
  // ****************************************************************
  always_comb begin
    next_hrdata = hrdata;
    if (addrPhase & ~hwrite) begin
      unique case (haddr[11:0])
        `OFS_MODE_CONFIG0: begin
          next_hrdata = {22'h0, next_pattern, 7'h00, next_rampSel};
        end
        `OFS_FRAME_DELIM: begin
          next_hrdata = {24'h000000, next_delim};
        end
        `OFS_SCAN_REPEAT: begin
          next_hrdata = {8'h00, next_repeatCnt};
        end
        `OFS_ENERGY_LEVEL: begin
          next_hrdata = {25'h0, next_energyLevel};
        end
        `OFS_SCAN_STATUS: begin
          next_hrdata = {31'h0, scanLink.busy};
        end
        default: begin
          next_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // ****************************************************************
  // idle transmit window and pattern
  // ****************************************************************
  always_comb begin
    next_idleWindow = idleWindow;
    if (readyEvent | endEvent) begin
      next_idleWindow = 1'b1;
    end
    if (startTask | disabledEvent) begin
      next_idleWindow = 1'b0;
    end
    next_idleTxOne     = 1'b0;
    next_idleTxZero    = 1'b0;
    next_idleTxCarrier = 1'b0;
    if (next_idleWindow) begin
      unique case (pattern)
        PATTERN_ONE: begin
          next_idleTxOne = 1'b1;
        end
        PATTERN_ZERO: begin
          next_idleTxZero = 1'b1;
        end
        default: begin
          // code 3 is not defined; fall back to the carrier
          next_idleTxCarrier = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // ramp-up selection
  // ****************************************************************
  always_comb begin
    next_rampupCycles = rampSel ? RampFast : RampStd;
    next_scanDone     = scanLink.done;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      idleWindow               <= 1'b0;
      idleTxActive             <= 1'b0;
      idleTxOne                <= 1'b0;
      idleTxZero               <= 1'b0;
      idleTxCarrier            <= 1'b0;
      rampSpeedSelect          <= 1'b0;
      rampupCycles             <= RampStd;
      interframeSpacingEnforce <= 1'b1;
      frameDelimiter           <= `RST_FRAME_DELIM;
      energyScanDone           <= 1'b0;
    end else begin
      idleWindow               <= next_idleWindow;
      idleTxActive             <= next_idleWindow;
      idleTxOne                <= next_idleTxOne;
      idleTxZero               <= next_idleTxZero;
      idleTxCarrier            <= next_idleTxCarrier;
      rampSpeedSelect          <= rampSel;
      rampupCycles             <= next_rampupCycles;
      interframeSpacingEnforce <= ~rampSel;
      frameDelimiter           <= delim;
      energyScanDone           <= next_scanDone;
    end
  end

endmodule // radio_mode_energy_detect_regs

// >>> tb/radio_mode_energy_detect_regs_assertions.sv
`timescale 1ns/1ps
`include "radio_mode_regs.svh"
module radio_mode_energy_detect_regs_assertions (
  input wire logic                       mclk,                     // clock
  input wire logic                       sys_rst,                  // reset
  input wire logic                       hsel,                     // select
  input wire logic [31:0]                haddr,                    // address
  input wire logic [1:0]                 htrans,                   // transfer type
  input wire logic                       hwrite,                   // write
  input wire logic [31:0]                hwdata,                   // write data
  input wire logic                       hready,                   // bus ready
  input wire logic [31:0]                hrdata,                   // read data
  input wire logic                       readyEvent,               // opens window
  input wire logic                       startTask,                // closes window
  input wire logic                       endEvent,                 // opens window
  input wire logic                       disabledEvent,            // closes window
  input wire logic                       energySampleValid,        // scan result
  input wire logic                       energyScanDone,           // operation ended
  input wire logic                       rampSpeedSelect,          // fast ramp
  input wire logic [`RAMP_CNT_WIDTH-1:0] rampupCycles,             // ramp length
  input wire logic                       interframeSpacingEnforce, // hw spacing
  input wire logic                       idleTxActive,             // window open
  input wire logic                       idleTxOne,                // one symbol
  input wire logic                       idleTxZero,               // zero symbol
  input wire logic                       idleTxCarrier,            // carrier
  input wire logic [`DELIM_WIDTH-1:0]    frameDelimiter            // delimiter
);
  logic take;
  assign take = hsel & htrans[1] & hready;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_ramp_len;
    rampupCycles == (rampSpeedSelect ? 12'h190 : 12'hfa0);
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("ramp length wrong");
  property p_spacing;
    interframeSpacingEnforce != rampSpeedSelect;
  endproperty
  a_spacing: assert property (p_spacing) else $error("spacing flag wrong");
  property p_ramp_bit;
    take && hwrite && haddr[11:0] == 12'h650 |=> ##2 rampSpeedSelect == $past(hwdata[0], 2);
  endproperty
  a_ramp_bit: assert property (p_ramp_bit) else $error("ramp bit wrong");
  property p_open;
    (readyEvent || endEvent) && !startTask && !disabledEvent |=> idleTxActive;
  endproperty
  a_open: assert property (p_open) else $error("idle window not open");
  property p_close;
    startTask || disabledEvent |=> !idleTxActive;
  endproperty
  a_close: assert property (p_close) else $error("idle window not closed");
  property p_pattern;
    idleTxActive ? $onehot({idleTxOne, idleTxZero, idleTxCarrier})
                 : {idleTxOne, idleTxZero, idleTxCarrier} == 3'h0;
  endproperty
  a_pattern: assert property (p_pattern) else $error("idle pattern wrong");
  property p_delim;
    take && hwrite && haddr[11:0] == 12'h660 |=> ##2 frameDelimiter == $past(hwdata[7:0], 2);
  endproperty
  a_delim: assert property (p_delim) else $error("delimiter wrong");
  property p_done;
    energyScanDone |-> $past(energySampleValid, 2) ##1 !energyScanDone;
  endproperty
  a_done: assert property (p_done) else $error("scan done wrong");
  property p_level;
    take && !hwrite && haddr[11:0] == 12'h668 |=> hrdata[31:7] == 25'h0;
  endproperty
  a_level: assert property (p_level) else $error("level out of range");
endmodule // radio_mode_energy_detect_regs_assertions

bind radio_mode_energy_detect_regs radio_mode_energy_detect_regs_assertions i_chk (
  .mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .readyEvent, .startTask, .endEvent, .disabledEvent, .energySampleValid,
  .energyScanDone, .rampSpeedSelect, .rampupCycles, .interframeSpacingEnforce,
  .idleTxActive, .idleTxOne, .idleTxZero, .idleTxCarrier, .frameDelimiter);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "radio_mode_regs.svh"
module tb_top;
  import radio_mode_pkg::*;
  logic                       mclk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       hsel = 1'b0;
  logic                       hwrite = 1'b0;
  logic [1:0]                 htrans = 2'h0;
  logic [31:0]                haddr = 32'h0;
  logic [31:0]                hwdata = 32'h0;
  logic [3:0]                 evs = 4'h0;
  logic                       energyScanStart = 1'b0;
  logic                       energySampleValid = 1'b0;
  level_t                     energySample = 7'h00;
  logic                       hreadyout, hresp, energyScanDone, rampSpeedSelect;
  logic                       interframeSpacingEnforce, idleTxActive;
  logic                       idleTxOne, idleTxZero, idleTxCarrier;
  logic [31:0]                hrdata;
  logic [31:0]                idleBits;
  logic [`RAMP_CNT_WIDTH-1:0] rampupCycles;
  logic [`DELIM_WIDTH-1:0]    frameDelimiter;
  logic                       rdPh = 1'b0;
  logic                       idPh = 1'b0;
  logic [7:0]                 nSamp = 8'h0;
  logic [31:0]                rdQ[$], idQ[$];
  logic [7:0]                 scQ[$];
  int                         miscompares = 0;
  int                         checked = 0;
  int                         cyc = 0;

  always #5 mclk = ~mclk;

  assign idleBits = {28'h0, idleTxActive, idleTxOne, idleTxZero, idleTxCarrier};

  radio_mode_energy_detect_regs i_radio_mode_energy_detect_regs (
    .mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .readyEvent(evs[0]),
    .startTask(evs[1]), .endEvent(evs[2]), .disabledEvent(evs[3]), .energyScanStart,
    .energySampleValid, .energySample, .energyScanDone, .rampSpeedSelect, .rampupCycles,
    .interframeSpacingEnforce, .idleTxActive, .idleTxOne, .idleTxZero, .idleTxCarrier,
    .frameDelimiter);

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic cmpReg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmpScan(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    if (scQ.size() != 0) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (rdPh && hreadyout) cmpReg(hrdata, rdQ.pop_front());
    if (idPh) cmpReg(idleBits, idQ.pop_front());
    if (energyScanStart) nSamp = 8'h0;
    if (energySampleValid) nSamp++;
    if (energyScanDone) cmpScan(nSamp, scQ.pop_front());
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************************************
  // bus and event drivers
  // ****************************************************************
  task automatic busAddr(input logic [11:0] a, input logic w);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    busAddr(a, 1'b1);
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    busAddr(a, 1'b0);
    rdQ.push_back(e);
    rdPh <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdPh <= 1'b0;
  endtask

  task automatic idle(input logic [3:0] e, input logic [31:0] x);
    @(posedge mclk);
    evs <= e;
    @(posedge mclk);
    evs <= 4'h0;
    idQ.push_back(x);
    idPh <= 1'b1;
    @(posedge mclk);
    idPh <= 1'b0;
  endtask

  task automatic scan(input logic [7:0] n);
    level_t mx, v;
    mx = 7'h00;
    wr(12'h664, {24'h0, n});
    rd(12'h664, {24'h0, n});
    @(posedge mclk);
    energySample <= 7'h7f;
    energySampleValid <= 1'b1;
    scQ.push_back(n + 8'h1);
    @(posedge mclk);
    energySampleValid <= 1'b0;
    energyScanStart <= 1'b1;
    @(posedge mclk);
    energyScanStart <= 1'b0;
    for (int i = 0; i <= int'(n); i++) begin
      @(posedge mclk);
      v = 7'($urandom_range(126, 0));
      if (v > mx) mx = v;
      energySample <= v;
      energySampleValid <= 1'b1;
      @(posedge mclk);
      energySampleValid <= 1'b0;
    end
    repeat (3) @(posedge mclk);
    rd(12'h668, {25'h0, mx});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    void'($urandom(20));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(12'h650, 32'h200);
    rd(12'h660, 32'ha7);
    rd(12'h664, 32'h0);
    rd(12'h668, 32'h0);
    rd(12'h7f0, 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      wr(12'h650, {22'h0, p[1:0], 7'h0, p[0]});
      rd(12'h650, {22'h0, p[1:0], 7'h0, p[0]});
      idle(p[0] ? 4'h4 : 4'h1, {28'h0, 1'b1, p == 0, p == 1, p > 1});
      idle(p[0] ? 4'h8 : 4'h2, 32'h0);
    end
    wr(12'h650, 32'h200);
    rd(12'h650, 32'h200);
    idle(4'h1, 32'h9);
    idle(4'h2, 32'h0);
    $display("test mode and idle pattern done");
    d = $urandom;
    wr(12'h660, d);
    rd(12'h660, {24'h0, d[7:0]});
    wr(12'h668, 32'hffffffff);
    rd(12'h668, 32'h7f);
    wr(12'h670, 32'h1);
    rd(12'h670, 32'h0);
    $display("test delimiter and level done");
    scan(8'h0);
    scan(8'h3);
    $display("test energy scan done");
    end_sim();
  end
endmodule // tb_top
